// >>> core/gp_timer_pkg.sv
// Functional notes
// [RULE_01] RTC mode: one 32-bit up-counter
// [RULE_02] first RTC selection presets count to one
// [RULE_03] pin 32.768 kHz clock divided to 1 Hz
// [RULE_04] RTC match wraps count to zero
// [RULE_05] RTC match sets raw, masked flag, interrupt
// [RULE_06] RTC stall override ignores both stall bits
// [RULE_07] configuration four gives two split timers
// [RULE_08] one-shot/periodic count down with prescaler
// [RULE_09] at zero reload; one-shot clears enable
// [RULE_10] timeout sets sticky flag, optional trigger pulse
// [RULE_11] new interval load applied next cycle
// [RULE_12] stall bit freezes the counter
// [RULE_13] step every prescale plus one clocks
// [RULE_14] source holds edge level at least two clocks
// [RULE_15] prescaler bypassed in capture and PWM modes
// [RULE_16] edge count: down-counter, selectable edges
// [RULE_17] edge count match: flag, reload, disable
// [RULE_18] edge time: free-running down-counter, one edge
// [RULE_19] edge time: capture count, set event flag
// [RULE_20] PWM when alternate, no capture, periodic
// [RULE_21] PWM reloads at zero, no flags
// [RULE_22] PWM high at start, low at match
// [RULE_23] mode field: 1 one-shot, 2 periodic, 3 capture
// [RULE_24] reset: counters, loads all ones, prescale zero
// [RULE_25] capture pins synchronised, edges from samples
`default_nettype none
package gp_timer_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MODE_A = 8'h04;
  localparam logic [7:0] OFF_MODE_B = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_IMR = 8'h10;
  localparam logic [7:0] OFF_RIS = 8'h14;
  localparam logic [7:0] OFF_MIS = 8'h18;
  localparam logic [7:0] OFF_ICR = 8'h1C;
  localparam logic [7:0] OFF_ILR_A = 8'h20;
  localparam logic [7:0] OFF_ILR_B = 8'h24;
  localparam logic [7:0] OFF_MATCH_A = 8'h28;
  localparam logic [7:0] OFF_MATCH_B = 8'h2C;
  localparam logic [7:0] OFF_PR_A = 8'h30;
  localparam logic [7:0] OFF_PR_B = 8'h34;
  localparam logic [7:0] OFF_TR_A = 8'h38;
  localparam logic [7:0] OFF_TR_B = 8'h3C;
  // ---------------------------------------------------------------
  // fields and codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam int MR_CMR = 2;
  localparam int MR_AMS = 3;
  localparam int CTL_EN = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_EVT = 2;
  localparam int CTL_RTC_OVR = 4;
  localparam int CTL_OTE = 5;
  localparam int CTL_INV = 6;
  localparam int CTL_B = 8;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_BOTH = 2'h3;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_CMATCH = 1;
  localparam int ST_CEVENT = 2;
  localparam int ST_RTC = 3;
  localparam int ST_B = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam logic [15:0] ILR_RST = 16'hFFFF;
  localparam logic [7:0] PR_RST = 8'h00;
  localparam logic [31:0] RTC_PRESET = 32'h0000_0001;
  localparam logic [31:0] RTC_WRAP = 32'h0000_0000;
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV = RTC_IN_HZ / RTC_TICK_HZ;
  localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_DIV - 1);
  typedef enum logic [5:0] {
    K_OFF = 6'h01,
    K_OS = 6'h02,
    K_PER = 6'h04,
    K_ECNT = 6'h08,
    K_ETIME = 6'h10,
    K_PWM = 6'h20
  } tkind_e;
endpackage
`default_nettype wire

// >>> core/gp_timer_rtc_capture_pwm.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module gp_timer_rtc_capture_pwm import gp_timer_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // capture/compare pins and events
  input wire logic [1:0] ccpIn,
  output logic [1:0] ccpOut,
  output logic [1:0] ccpOe,
  output logic [1:0] trigOut,
  output logic ctrlIrq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] cfg_q, cfg_d;
  logic [3:0] mode_q [2];
  logic [3:0] mode_d [2];
  logic [15:0] ctl_q, ctl_d, imr_q, imr_d, ris_q, ris_d;
  logic [15:0] ilr_q [2];
  logic [15:0] ilr_d [2];
  logic [15:0] match_q [2];
  logic [15:0] match_d [2];
  logic [15:0] matchHi_q, matchHi_d;
  logic [7:0] pr_q [2];
  logic [7:0] pr_d [2];
  logic [1:0] ilrLd_q, ilrLd_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awReady_q, awReady_d, wReady_q, wReady_d;
  logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic irq_q, irq_d;
  logic [1:0] s1_q, s2_q, s3_q;
  logic [15:0] cnt_q [2];
  logic [15:0] cap_q [2];
  logic [7:0] pre_q [2];
  logic [1:0] pwm_q, trig_q, out_q, oe_q;
  logic [31:0] rtcCnt_q, rtcCnt_d;
  logic [14:0] rtcDiv_q, rtcDiv_d;
  logic rtcSeen_q, rtcSeen_d, rtcFlag;
  logic doWrite;
  logic [15:0] clr, sets;
  logic [2:0] fl [2];
  logic [1:0] hwClrEn;
  logic [1:0] rise, fall;
  tkind_e kind [2];

  // ---------------------------------------------------------------
  // read mux, {ok, data}
  // ---------------------------------------------------------------
  function automatic logic [32:0] rdMux(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      OFF_CFG: r[2:0] = cfg_q;
      OFF_MODE_A: r[3:0] = mode_q[0];
      OFF_MODE_B: r[3:0] = mode_q[1];
      OFF_CTL: r[15:0] = ctl_q;
      OFF_IMR: r[15:0] = imr_q;
      OFF_RIS: r[15:0] = ris_q;
      OFF_MIS: r[15:0] = ris_q & imr_q;
      OFF_ICR: r[15:0] = 16'h0000;
      OFF_ILR_A: r[15:0] = ilr_q[0];
      OFF_ILR_B: r[15:0] = ilr_q[1];
      OFF_MATCH_A: r[31:0] = {matchHi_q, match_q[0]};
      OFF_MATCH_B: r[15:0] = match_q[1];
      OFF_PR_A: r[7:0] = pr_q[0];
      OFF_PR_B: r[7:0] = pr_q[1];
      OFF_TR_A: begin
        if (cfg_q == CFG_RTC) begin
          r[31:0] = rtcCnt_q;
        end else begin
          r[15:0] = (kind[0] == K_ETIME) ? cap_q[0] : cnt_q[0];
        end
      end
      OFF_TR_B: r[15:0] = (kind[1] == K_ETIME) ? cap_q[1] : cnt_q[1];
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // bus slave and register file
  // ---------------------------------------------------------------
  always_comb begin
    logic [32:0] old;
    logic [31:0] m;
    logic [31:0] wv;
    old = rdMux(awAddr_q);
    m = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wv = (old[31:0] & ~m) | (wData_q & m);
    doWrite = awHave_q & wHave_q & ~bValid_q;
    awHave_d = (awHave_q & ~doWrite) | (s_axi_awvalid & awReady_q);
    wHave_d = (wHave_q & ~doWrite) | (s_axi_wvalid & wReady_q);
    awAddr_d = (s_axi_awvalid & awReady_q) ? s_axi_awaddr : awAddr_q;
    wData_d = (s_axi_wvalid & wReady_q) ? s_axi_wdata : wData_q;
    wStrb_d = (s_axi_wvalid & wReady_q) ? s_axi_wstrb : wStrb_q;
    awReady_d = ~awHave_d;
    wReady_d = ~wHave_d;
    bValid_d = doWrite | (bValid_q & ~s_axi_bready);
    bResp_d = bResp_q;
    if (doWrite) begin
      bResp_d = old[32] ? RESP_OKAY : RESP_SLVERR;
    end
    rValid_d = (s_axi_arvalid & arReady_q) | (rValid_q & ~s_axi_rready);
    arReady_d = ~rValid_d;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_arvalid & arReady_q) begin
      {rResp_d[1], rData_d} = rdMux(s_axi_araddr) ^ {1'b1, 32'h0000_0000};
      rResp_d[0] = 1'b0;
    end
    cfg_d = cfg_q;
    mode_d = mode_q;
    ctl_d = ctl_q;
    imr_d = imr_q;
    ilr_d = ilr_q;
    match_d = match_q;
    matchHi_d = matchHi_q;
    pr_d = pr_q;
    ilrLd_d = 2'b00;
    clr = 16'h0000;
    if (doWrite) begin
      case (awAddr_q)
        OFF_CFG: cfg_d = wv[2:0]; // [RULE_07]
        OFF_MODE_A: mode_d[0] = wv[3:0];
        OFF_MODE_B: mode_d[1] = wv[3:0];
        OFF_CTL: ctl_d = wv[15:0];
        OFF_IMR: imr_d = wv[15:0];
        OFF_ICR: clr = wv[15:0];
        OFF_ILR_A: begin
          ilr_d[0] = wv[15:0];
          ilrLd_d[0] = 1'b1;
        end
        OFF_ILR_B: begin
          ilr_d[1] = wv[15:0];
          ilrLd_d[1] = 1'b1;
        end
        OFF_MATCH_A: {matchHi_d, match_d[0]} = wv;
        OFF_MATCH_B: match_d[1] = wv[15:0];
        OFF_PR_A: pr_d[0] = wv[7:0];
        OFF_PR_B: pr_d[1] = wv[7:0];
        default: ;
      endcase
    end
    // one-shot end and edge-count match drop enable
    ctl_d[CTL_EN] = ctl_d[CTL_EN] & ~hwClrEn[0]; // [RULE_09]
    ctl_d[CTL_B + CTL_EN] = ctl_d[CTL_B + CTL_EN] & ~hwClrEn[1]; // [RULE_17]
    sets = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      sets[k] = fl[0][k];
      sets[ST_B + k] = fl[1][k];
    end
    sets[ST_RTC] = rtcFlag; // [RULE_05]
    ris_d = (ris_q & ~clr) | sets; // [RULE_10]
    irq_d = |(ris_d & imr_q); // [RULE_05]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 3'h0; // [RULE_24]
      mode_q <= '{default: 4'h0};
      ctl_q <= 16'h0000;
      imr_q <= 16'h0000;
      ris_q <= 16'h0000;
      ilr_q <= '{default: ILR_RST};
      match_q <= '{default: 16'h0000};
      matchHi_q <= 16'h0000;
      pr_q <= '{default: PR_RST};
      ilrLd_q <= 2'b00;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rResp_q <= RESP_OKAY;
      rData_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      ctl_q <= ctl_d;
      imr_q <= imr_d;
      ris_q <= ris_d;
      ilr_q <= ilr_d;
      match_q <= match_d;
      matchHi_q <= matchHi_d;
      pr_q <= pr_d;
      ilrLd_q <= ilrLd_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      irq_q <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
      s3_q <= 2'b00;
    end else begin
      s1_q <= ccpIn; // [RULE_25]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q; // [RULE_25]
  assign fall = ~s2_q & s3_q;

  // ---------------------------------------------------------------
  // real-time counter
  // ---------------------------------------------------------------
  always_comb begin
    logic stallOk;
    stallOk = ~(ctl_q[CTL_STALL] | ctl_q[CTL_B + CTL_STALL])
              | ctl_q[CTL_RTC_OVR]; // [RULE_06]
    rtcCnt_d = rtcCnt_q;
    rtcDiv_d = rtcDiv_q;
    rtcSeen_d = rtcSeen_q;
    rtcFlag = 1'b0;
    if (cfg_q == CFG_RTC) begin
      if (!rtcSeen_q) begin
        rtcCnt_d = RTC_PRESET; // [RULE_02]
        rtcSeen_d = 1'b1;
        rtcDiv_d = 15'h0000;
      end else if (ctl_q[CTL_EN] && stallOk && rise[0]) begin
        if (rtcDiv_q == RTC_DIV_LAST) begin
          rtcDiv_d = 15'h0000; // [RULE_03]
          if (rtcCnt_q == {matchHi_q, match_q[0]}) begin
            rtcCnt_d = RTC_WRAP; // [RULE_04]
            rtcFlag = 1'b1; // [RULE_05]
          end else begin
            rtcCnt_d = rtcCnt_q + 32'h0000_0001; // [RULE_01]
          end
        end else begin
          rtcDiv_d = rtcDiv_q + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcCnt_q <= 32'h0000_0000;
      rtcDiv_q <= 15'h0000;
      rtcSeen_q <= 1'b0;
    end else begin
      rtcCnt_q <= rtcCnt_d;
      rtcDiv_q <= rtcDiv_d;
      rtcSeen_q <= rtcSeen_d;
    end
  end

  AST_RTC_PRESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_q == CFG_RTC && !rtcSeen_q |=> rtcCnt_q == RTC_PRESET) // [RULE_02]
    else $error("rtc count not preset to one");
  AST_RTC_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    rtcFlag |=> rtcCnt_q == RTC_WRAP && ris_q[ST_RTC]) // [RULE_04]
    else $error("rtc match did not wrap and flag");
  AST_RTC_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    rtcSeen_q && rtcCnt_d != rtcCnt_q && !rtcFlag
    |-> rtcCnt_d == rtcCnt_q + 32'h0000_0001 && rtcDiv_q == RTC_DIV_LAST)
    // [RULE_03]
    else $error("rtc step without full divide");

  // ---------------------------------------------------------------
  // split timers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    localparam int CB = i * CTL_B;
    localparam int SB = i * ST_B;
    logic [15:0] cnt_d, cap_d, dec;
    logic [7:0] pre_d;
    logic pwm_d, trig_d, run, evt, stall;
    logic [1:0] evSel;
    assign dec = cnt_q[i] - 16'h0001;
    assign evSel = ctl_q[CB + CTL_EVT +: 2];
    assign stall = ctl_q[CB + CTL_STALL];
    assign run = cfg_q == CFG_SPLIT && ctl_q[CB + CTL_EN] && !stall;

    always_comb begin
      logic [3:0] md;
      md = mode_q[i];
      case (md[1:0]) // [RULE_23]
        MODE_ONESHOT: kind[i] = md[MR_AMS] ? K_OFF : K_OS;
        MODE_PERIODIC: begin
          kind[i] = (md[MR_AMS] && !md[MR_CMR]) ? K_PWM : K_PER; // [RULE_20]
        end
        MODE_CAPTURE: kind[i] = md[MR_CMR] ? K_ETIME : K_ECNT;
        default: kind[i] = K_OFF;
      endcase
      // edge time never takes both edges
      if (evSel == EVT_BOTH && kind[i] == K_ECNT) begin
        evt = rise[i] | fall[i]; // [RULE_16]
      end else if (evSel == EVT_FALL) begin
        evt = fall[i];
      end else begin
        evt = rise[i]; // [RULE_18]
      end
    end

    always_comb begin
      cnt_d = cnt_q[i];
      pre_d = pre_q[i];
      cap_d = cap_q[i];
      pwm_d = pwm_q[i];
      trig_d = 1'b0;
      fl[i] = 3'b000;
      hwClrEn[i] = 1'b0;
      if (ilrLd_q[i]) begin
        cnt_d = ilr_q[i]; // [RULE_11]
        pre_d = pr_q[i];
      end else if (run) begin // [RULE_12]
        case (kind[i])
          K_OS, K_PER: begin // [RULE_08]
            if (pre_q[i] != PR_RST) begin
              pre_d = pre_q[i] - 8'h01; // [RULE_13]
            end else begin
              pre_d = pr_q[i];
              if (cnt_q[i] == 16'h0000) begin
                cnt_d = ilr_q[i]; // [RULE_09]
                fl[i][ST_TIMEOUT] = 1'b1; // [RULE_10]
                trig_d = ctl_q[CB + CTL_OTE]; // [RULE_10]
                hwClrEn[i] = kind[i] == K_OS; // [RULE_09]
              end else begin
                cnt_d = dec;
              end
            end
          end
          K_ECNT: begin // [RULE_15]
            if (evt) begin
              if (dec == match_q[i]) begin
                cnt_d = ilr_q[i]; // [RULE_17]
                fl[i][ST_CMATCH] = 1'b1;
                hwClrEn[i] = 1'b1;
              end else begin
                cnt_d = dec; // [RULE_16]
              end
            end
          end
          K_ETIME: begin
            cnt_d = (cnt_q[i] == 16'h0000) ? ilr_q[i] : dec; // [RULE_18]
            if (evt) begin
              cap_d = cnt_q[i]; // [RULE_19]
              fl[i][ST_CEVENT] = 1'b1;
            end
          end
          K_PWM: begin
            cnt_d = (cnt_q[i] == 16'h0000) ? ilr_q[i] : dec; // [RULE_21]
            if (cnt_q[i] == ilr_q[i]) begin
              pwm_d = 1'b1; // [RULE_22]
            end else if (cnt_q[i] == match_q[i]) begin
              pwm_d = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q[i] <= CNT_RST; // [RULE_24]
        pre_q[i] <= PR_RST;
        cap_q[i] <= CNT_RST;
        pwm_q[i] <= 1'b0;
        trig_q[i] <= 1'b0;
        out_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_d;
        pre_q[i] <= pre_d;
        cap_q[i] <= cap_d;
        pwm_q[i] <= pwm_d;
        trig_q[i] <= trig_d;
        out_q[i] <= pwm_d ^ ctl_q[CB + CTL_INV]; // [RULE_22]
        oe_q[i] <= kind[i] == K_PWM && cfg_q == CFG_SPLIT
                   && ctl_q[CB + CTL_EN];
      end
    end

    sequence seqOneShotEnd;
      run && kind[i] == K_OS && pre_q[i] == PR_RST
      && cnt_q[i] == 16'h0000 && !ilrLd_q[i];
    endsequence
    sequence seqStopped;
      !ctl_q[CB + CTL_EN] && ris_q[SB + ST_TIMEOUT];
    endsequence
    AST_ONESHOT_STOP: assert property (@(posedge core_clk)
      disable iff (!rst_n) seqOneShotEnd |=> seqStopped) // [RULE_09]
      else $error("one-shot did not stop with flag");
    AST_STALL_FREEZE: assert property (@(posedge core_clk)
      disable iff (!rst_n) stall && !ilrLd_q[i] |=> $stable(cnt_q[i]))
      // [RULE_12]
      else $error("counter moved while stalled");
    AST_ILR_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      ilrLd_q[i] |=> cnt_q[i] == $past(ilr_q[i])) // [RULE_11]
      else $error("interval load not applied");
    AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
      run && kind[i] == K_ETIME && evt && !ilrLd_q[i]
      |=> cap_q[i] == $past(cnt_q[i]) && ris_q[SB + ST_CEVENT]) // [RULE_19]
      else $error("edge time capture missing");
    AST_ECNT_MATCH: assert property (@(posedge core_clk)
      disable iff (!rst_n) fl[i][ST_CMATCH]
      |=> !ctl_q[CB + CTL_EN] && cnt_q[i] == $past(ilr_q[i])) // [RULE_17]
      else $error("edge count match did not stop");
    AST_PWM_QUIET: assert property (@(posedge core_clk) // [RULE_21]
      disable iff (!rst_n) kind[i] == K_PWM
      |=> (ris_q[SB +: 3] & ~$past(ris_q[SB +: 3])) == 3'b000)
      else $error("pwm mode raised status");
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rvalid = rValid_q;
  assign ccpOut = out_q;
  assign ccpOe = oe_q;
  assign trigOut = trig_q;
  assign ctrlIrq = irq_q;
endmodule // gp_timer_rtc_capture_pwm
`default_nettype wire

// >>> test/ccp_source.sv
`default_nettype none
module ccp_source (
  // clock and pins
  input wire logic core_clk,
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 2'h0;
  // -------------------------------------------------------------
  // edge source: toggles one pin n times, level held h clocks
  // -------------------------------------------------------------
  task automatic edges(input int b, input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      repeat (h) @(posedge core_clk);
      pin[b] <= ~pin[b];
    end
  endtask
endmodule // ccp_source
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb import gp_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, ccpIn, ccpOut, ccpOe, trigOut;
  logic [31:0] rdata, n;
  logic [31:0] expq[$];
  int mismatches = 0;
  int totalChecks = 0;
  int seed = 82;
  int pr, ilr, g, hold;
  ccp_source src_u (.core_clk(core_clk), .pin(ccpIn));
  gp_timer_rtc_capture_pwm dut_u (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ccpIn(ccpIn),
    .ccpOut(ccpOut), .ccpOe(ccpOe), .trigOut(trigOut), .ctrlIrq(irq));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // -------------------------------------------------------------
  // bus tasks and checks
  // -------------------------------------------------------------
  task automatic tally_and_finish;
    if (expq.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
  endtask
  // oldest note against each read answer
  always @(posedge core_clk) begin
    if (rvalid === 1'b1 && expq.size() > 0) cmp(rdata, expq.pop_front());
  end
  task automatic trig_gap(input int b, output int gap);
    int t;
    t = 0;
    while (trigOut[b] !== 1'b1 && t < 500) begin
      @(posedge core_clk);
      t++;
    end
    @(posedge core_clk);
    gap = 1;
    while (trigOut[b] !== 1'b1 && gap < 500) begin
      @(posedge core_clk);
      gap++;
    end
  endtask
  task automatic sum_level(input int sel, input int b, input int w,
                           output logic [31:0] c);
    c = 32'h0;
    repeat (w) begin
      @(posedge core_clk);
      c = c + (sel ? ccpOut[b] : trigOut[b]);
    end
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFF_ILR_A, 32'h0000FFFF);
    rd(OFF_TR_B, 32'h0000FFFF);
    rd(OFF_PR_A, 32'h0);
    rd(OFF_CTL, 32'h0);
    rd(8'h40, 32'h0);
    wr(OFF_CFG, 32'h1);
    rd(OFF_TR_A, 32'h1);
    wr(OFF_CFG, 32'h4);
    wr(OFF_MODE_A, 32'h2);
    pr = $random(seed) & 3;
    ilr = 2 + ($random(seed) & 3);
    wr(OFF_PR_A, pr);
    wr(OFF_ILR_A, ilr);
    wr(OFF_IMR, 32'h1);
    wr(OFF_CTL, 32'h21);
    trig_gap(0, g);
    cmp(g, (ilr + 1) * (pr + 1));
    rd(OFF_RIS, 32'h1);
    cmp(irq, 32'h1);
    ilr = ilr + 3;
    wr(OFF_ILR_A, ilr);
    trig_gap(0, g);
    cmp(g, (ilr + 1) * (pr + 1));
    wr(OFF_CTL, 32'h23);
    sum_level(0, 0, 80, n);
    cmp(n, 32'h0);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'hFFFF);
    rd(OFF_RIS, 32'h0);
    wr(OFF_MODE_B, 32'h1);
    wr(OFF_ILR_B, 32'h5);
    wr(OFF_CTL, 32'h2100);
    repeat (20) @(posedge core_clk);
    rd(OFF_CTL, 32'h2000);
    rd(OFF_TR_B, 32'h5);
    rd(OFF_RIS, 32'h100);
    cmp(irq, 32'h0);
    wr(OFF_ICR, 32'hFFFF);
    wr(OFF_MODE_A, 32'h3);
    for (int e = 0; e < 4; e++) begin
      if (e == 2) continue;
      hold = 2 + ($random(seed) & 3);
      wr(OFF_ILR_A, 32'hA);
      wr(OFF_CTL, 1 | (e << 2));
      src_u.edges(0, 3, hold);
      repeat (6) @(posedge core_clk);
      rd(OFF_TR_A, 10 - (e == 3 ? 3 : 2 - e));
      wr(OFF_CTL, 32'h0);
      src_u.edges(0, 1, hold);
    end
    wr(OFF_MATCH_A, 32'h6);
    wr(OFF_ILR_A, 32'hA);
    wr(OFF_CTL, 32'hD);
    src_u.edges(0, 6, 3);
    repeat (6) @(posedge core_clk);
    rd(OFF_TR_A, 32'hA);
    rd(OFF_CTL, 32'hC);
    rd(OFF_RIS, 32'h2);
    wr(OFF_ICR, 32'hFFFF);
    // edge time: capture six counts after enable plus hold
    wr(OFF_MODE_A, 32'h7);
    wr(OFF_ILR_A, 32'h40);
    wr(OFF_CTL, 32'h1);
    src_u.edges(0, 1, 3);
    repeat (6) @(posedge core_clk);
    rd(OFF_TR_A, 32'h3A);
    rd(OFF_RIS, 32'h4);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'hFFFF);
    wr(OFF_MODE_B, 32'hA);
    wr(OFF_PR_B, 32'h3);
    wr(OFF_ILR_B, 32'h9);
    wr(OFF_MATCH_B, 32'h3);
    wr(OFF_CTL, 32'h100);
    repeat (4) @(posedge core_clk);
    cmp(ccpOe[1], 32'h1);
    sum_level(1, 1, 100, n);
    cmp(n, 32'h3C);
    wr(OFF_CTL, 32'h4100);
    sum_level(1, 1, 100, n);
    cmp(n, 32'h28);
    rd(OFF_RIS, 32'h0);
    repeat (2) @(posedge core_clk);
    tally_and_finish;
  end
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
